//--- logic/smart_charger_smbus_control.sv
`timescale 1ns/100ps
`default_nettype none
module smart_charger_smbus_control
	import smbus_charger_pkg::*;
#(
	// Revision code value is arbitrary.
	parameter logic [15:0] SPEC_REVISION_WORD = 16'h00A5
) (
	// Clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	// SMBus pins
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_n_o,
	// Comparator flags
	input  wire logic        adapter_ok_flag_i,
	input  wire logic        power_fail_i,
	input  wire logic        pack_present_i,
	input  wire logic        pack_uv_low_i,
	input  wire logic        pack_uv_high_i,
	input  wire logic        pack_overtemp_i,
	input  wire logic        pack_sense_underrange_i,
	input  wire logic        alarm_event_i,
	input  wire logic        logic_uv_i,
	// Charger controls
	output logic             charge_en_o,
	output logic             source_switch_drive_o,
	output logic [10:0]      volt_dac_o,
	output logic [5:0]       curr_dac_o
);

	typedef struct packed {
		logic                 scl_s1;
		logic                 scl_s2;
		logic                 scl_d;
		logic                 sda_s1;
		logic                 sda_s2;
		logic                 sda_d;
		logic [CMP_COUNT-1:0] cmp_s1;
		logic [CMP_COUNT-1:0] cmp_s2;
		smb_state_t           st;
		logic [3:0]           bitcnt;
		logic [1:0]           idx;
		logic                 rd;
		logic                 cmd_ok;
		logic                 rack;
		logic [7:0]           shift;
		logic [7:0]           cmd;
		logic [7:0]           lo_byte;
		logic [7:0]           hi_tx;
		logic                 sda_drive;
		logic                 sda_level;
		logic                 sda_release;
		logic                 inhibit;
		logic                 overtemp_halt_ctl;
		logic [15:0]          cur_word;
		logic [15:0]          volt_word;
		logic                 uv_latch;
		logic                 ot_latch;
		logic                 alarm_latch;
		logic [10:0]          volt_dac;
		logic [5:0]           curr_dac;
		logic                 charge_en;
		logic                 src_sw;
	} state_t;

	localparam state_t STATE_RESET = '{
		st:        ST_IDLE,
		overtemp_halt_ctl:  1'b1,
		sda_release: 1'b1,
		cur_word:  CURR_RESET,
		volt_word: VOLT_RESET,
		volt_dac:  VDAC_MAX,
		curr_dac:  CDAC_MIN,
		default:   '0
	};

	state_t s_reg;
	state_t s_next;

	logic [15:0] status_word;
	logic [CMP_COUNT-1:0] cmp_raw;

	assign cmp_raw = {logic_uv_i, alarm_event_i, pack_sense_underrange_i, pack_overtemp_i,
			pack_uv_high_i, pack_uv_low_i, pack_present_i, power_fail_i, adapter_ok_flag_i};

	always_comb begin
		status_word = 16'h0000;
		status_word[ST_ADAPTER_BIT] = s_reg.cmp_s2[CMP_ADAPTER];
		status_word[ST_PRESENT_BIT] = s_reg.cmp_s2[CMP_PRESENT];
		status_word[ST_PFAIL_BIT]   = s_reg.cmp_s2[CMP_PFAIL];
		status_word[ST_ALARM_BIT]   = s_reg.alarm_latch;
		status_word[ST_HOT_BIT]     = s_reg.ot_latch;
		status_word[ST_UR_BIT]      = s_reg.cmp_s2[CMP_UR];
		status_word[ST_HALT_BIT]    = s_reg.overtemp_halt_ctl;
		status_word[ST_INHIBIT_BIT] = s_reg.inhibit;
	end

	always_comb begin
		logic        scl_rise;
		logic        scl_fall;
		logic        start_cond;
		logic        stop_cond;
		logic        acc;
		logic        write_go;
		logic        present;
		logic        rd_cmd;
		logic [15:0] rd_word;
		logic [10:0] vcode;
		logic [5:0]  ccode;
		state_t      rv;
		scl_rise   = 1'b0;
		scl_fall   = 1'b0;
		start_cond = 1'b0;
		stop_cond  = 1'b0;
		acc        = 1'b0;
		write_go   = 1'b0;
		present    = 1'b0;
		rd_cmd     = 1'b0;
		rd_word    = 16'h0000;
		vcode      = 11'h000;
		ccode      = 6'h00;
		rv         = STATE_RESET;
		s_next     = s_reg;

		// Pins pass two flops; edge detection compares the second stage with a delayed copy of it.
		s_next.scl_s1 = scl_i;
		s_next.scl_s2 = s_reg.scl_s1;
		s_next.scl_d  = s_reg.scl_s2;
		s_next.sda_s1 = sda_i;
		s_next.sda_s2 = s_reg.sda_s1;
		s_next.sda_d  = s_reg.sda_s2;
		s_next.cmp_s1 = cmp_raw;
		s_next.cmp_s2 = s_reg.cmp_s1;

		scl_rise   = s_reg.scl_s2 && !s_reg.scl_d;
		scl_fall   = !s_reg.scl_s2 && s_reg.scl_d;
		start_cond = s_reg.scl_s2 && s_reg.scl_d && !s_reg.sda_s2 && s_reg.sda_d;
		stop_cond  = s_reg.scl_s2 && s_reg.scl_d && s_reg.sda_s2 && !s_reg.sda_d;
		present    = s_reg.cmp_s2[CMP_PRESENT];
		rd_cmd     = (s_reg.cmd == CMD_SPEC) || (s_reg.cmd == CMD_STATUS);
		rd_word    = (s_reg.cmd == CMD_SPEC) ? SPEC_REVISION_WORD : status_word;

		// Bus engine: it only ever drives SDA low for an acknowledge or a data bit.
		case (s_reg.st)
			ST_IDLE: begin
			end
			ST_RX: begin
				if (scl_rise) begin
					s_next.shift  = {s_reg.shift[6:0], s_reg.sda_s2};
					s_next.bitcnt = s_reg.bitcnt + 4'h1;
				end else if (scl_fall && s_reg.bitcnt == BITS_PER_BYTE) begin
					s_next.bitcnt = 4'h0;
					case (s_reg.idx)
						IDX_ADDR: begin
							acc = (s_reg.shift[7:1] == DEV_ADDR_8[7:1]) &&
								(!s_reg.shift[0] || (s_reg.cmd_ok && rd_cmd));
							s_next.rd = s_reg.shift[0];
						end
						IDX_CMD: begin
							acc = (s_reg.shift == CMD_SPEC) || (s_reg.shift == CMD_MODE) ||
								(s_reg.shift == CMD_STATUS) || (s_reg.shift == CMD_CURRENT) ||
								(s_reg.shift == CMD_VOLTAGE);
							s_next.cmd    = s_reg.shift;
							s_next.cmd_ok = acc;
						end
						IDX_LO: begin
							acc            = 1'b1;
							s_next.lo_byte = s_reg.shift;
						end
						default: begin
							acc = 1'b1;
						end
					endcase
					s_next.st        = acc ? ST_ACK : ST_IGNORE;
					s_next.sda_drive = acc;
				end
			end
			ST_ACK: begin
				if (scl_fall) begin
					s_next.sda_drive = 1'b0;
					if (s_reg.rd) begin
						// Low byte first, MSB first within each byte.
						s_next.shift     = rd_word[7:0];
						s_next.hi_tx     = rd_word[15:8];
						s_next.sda_drive = !rd_word[7];
						s_next.idx       = IDX_LO;
						s_next.st        = ST_TX;
					end else if (s_reg.idx == IDX_HI) begin
						write_go  = 1'b1;
						s_next.st = ST_IGNORE;
					end else begin
						s_next.idx = s_reg.idx + 2'h1;
						s_next.st  = ST_RX;
					end
				end
			end
			ST_TX: begin
				if (scl_rise) begin
					s_next.bitcnt = s_reg.bitcnt + 4'h1;
				end else if (scl_fall) begin
					if (s_reg.bitcnt == BITS_PER_BYTE) begin
						s_next.bitcnt    = 4'h0;
						s_next.sda_drive = 1'b0;
						s_next.st        = ST_RACK;
					end else begin
						s_next.shift     = {s_reg.shift[6:0], 1'b0};
						s_next.sda_drive = !s_reg.shift[6];
					end
				end
			end
			ST_RACK: begin
				if (scl_rise) begin
					s_next.rack = !s_reg.sda_s2;
				end else if (scl_fall) begin
					if (s_reg.rack && s_reg.idx == IDX_LO) begin
						s_next.shift     = s_reg.hi_tx;
						s_next.sda_drive = !s_reg.hi_tx[7];
						s_next.idx       = IDX_HI;
						s_next.st        = ST_TX;
					end else begin
						s_next.st = ST_IGNORE;
					end
				end
			end
			ST_IGNORE: begin
			end
			default: begin
				s_next.st = ST_IDLE;
			end
		endcase

		// A repeated start keeps the command byte so a read can follow it.
		if (stop_cond) begin
			s_next.st        = ST_IDLE;
			s_next.sda_drive = 1'b0;
			s_next.cmd_ok    = 1'b0;
		end
		if (start_cond) begin
			s_next.st        = ST_RX;
			s_next.bitcnt    = 4'h0;
			s_next.idx       = IDX_ADDR;
			s_next.sda_drive = 1'b0;
		end

		// Register writes, committed after the high byte is acknowledged.
		if (write_go) begin
			case (s_reg.cmd)
				CMD_MODE: begin
					s_next.inhibit  = s_reg.lo_byte[MODE_INHIBIT_BIT];
					s_next.overtemp_halt_ctl = s_reg.lo_byte[MODE_OVERTEMP_HALT_CTL_BIT];
					if (s_reg.lo_byte[MODE_POR_BIT]) begin
						s_next.inhibit     = 1'b0;
						s_next.overtemp_halt_ctl    = 1'b1;
						s_next.cur_word    = CURR_RESET;
						s_next.volt_word   = VOLT_RESET;
						s_next.ot_latch    = 1'b0;
						s_next.alarm_latch = 1'b0;
					end
				end
				CMD_CURRENT: begin
					s_next.cur_word    = {s_reg.shift, s_reg.lo_byte};
					s_next.alarm_latch = 1'b0;
				end
				CMD_VOLTAGE: begin
					s_next.volt_word   = {s_reg.shift, s_reg.lo_byte};
					s_next.alarm_latch = 1'b0;
				end
				default: begin
				end
			endcase
		end

		if (!present) begin
			s_next.inhibit     = 1'b0;
			s_next.overtemp_halt_ctl    = 1'b1;
			s_next.cur_word    = CURR_RESET;
			s_next.volt_word   = VOLT_RESET;
			s_next.ot_latch    = 1'b0;
			s_next.alarm_latch = 1'b0;
		end

		// Latch sets come last so an event in a clearing cycle survives.
		if (present && s_reg.cmp_s2[CMP_HOT]) begin
			s_next.ot_latch = 1'b1;
		end
		if (present && s_reg.cmp_s2[CMP_ALARM]) begin
			s_next.alarm_latch = 1'b1;
		end
		if (s_reg.cmp_s2[CMP_UV_LOW]) begin
			s_next.uv_latch = 1'b1;
		end else if (s_reg.cmp_s2[CMP_UV_HIGH]) begin
			s_next.uv_latch = 1'b0;
		end

		// DAC codes; stored setpoints are never rewritten by a clamp or cap.
		vcode = (s_reg.volt_word >= VOLT_MAX_MV) ? VDAC_MAX :
			s_reg.volt_word[VDAC_LSB_POS +: 11];
		ccode = (s_reg.cur_word > CURR_MAX_MA) ? CDAC_MAX :
			s_reg.cur_word[CDAC_LSB_POS +: 6];
		if (s_reg.uv_latch && ccode > CDAC_MIN) begin
			ccode = CDAC_MIN;
		end
		s_next.src_sw = !s_reg.cmp_s2[CMP_PFAIL];
		if (present) begin
			s_next.volt_dac  = vcode;
			s_next.curr_dac  = ccode;
			s_next.charge_en = s_reg.cmp_s2[CMP_ADAPTER] && !s_reg.cmp_s2[CMP_PFAIL] &&
				!s_reg.inhibit && (s_reg.volt_word >= VOLT_MIN_MV) &&
				(s_reg.cur_word >= CURR_MIN_MA) &&
				!(s_reg.ot_latch && s_reg.overtemp_halt_ctl);
		end else begin
			s_next.volt_dac  = VDAC_MAX;
			s_next.curr_dac  = CDAC_MIN;
			s_next.charge_en = s_reg.cmp_s2[CMP_ADAPTER] && !s_reg.cmp_s2[CMP_PFAIL];
		end

		// Logic undervoltage holds everything but the synchronisers and the source switch drive at defaults.
		if (s_reg.cmp_s2[CMP_LUV]) begin
			rv.scl_s1 = s_next.scl_s1;
			rv.scl_s2 = s_next.scl_s2;
			rv.scl_d  = s_next.scl_d;
			rv.sda_s1 = s_next.sda_s1;
			rv.sda_s2 = s_next.sda_s2;
			rv.sda_d  = s_next.sda_d;
			rv.cmp_s1 = s_next.cmp_s1;
			rv.cmp_s2 = s_next.cmp_s2;
			rv.src_sw = s_next.src_sw;
			s_next    = rv;
		end

		// The pin enable keeps a flop of its own so the output has no gate after it.
		s_next.sda_release = !s_next.sda_drive;
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			s_reg <= STATE_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	assign sda_o                 = s_reg.sda_level;
	assign sda_oe_n_o            = s_reg.sda_release;
	assign charge_en_o           = s_reg.charge_en;
	assign source_switch_drive_o = s_reg.src_sw;
	assign volt_dac_o            = s_reg.volt_dac;
	assign curr_dac_o            = s_reg.curr_dac;

	a_pfail_switch_off: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		s_reg.cmp_s2[CMP_PFAIL] |=> !source_switch_drive_o)
		else $error("source switch on during power fail");

	a_absent_regs_reset: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		!s_reg.cmp_s2[CMP_PRESENT] |=> (s_reg.cur_word == CURR_RESET) &&
		(s_reg.volt_word == VOLT_RESET) && s_reg.overtemp_halt_ctl)
		else $error("command registers not reset without battery");

	a_absent_dac_forced: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		!s_reg.cmp_s2[CMP_PRESENT] && !s_reg.cmp_s2[CMP_LUV] |=>
		(volt_dac_o == VDAC_MAX) && (curr_dac_o == CDAC_MIN))
		else $error("no-battery regulation point wrong");

	a_uv_current_cap: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		s_reg.uv_latch && $past(s_reg.uv_latch) |-> curr_dac_o <= CDAC_MIN)
		else $error("current not capped in undervoltage");

	a_luv_quiet_bus: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		s_reg.cmp_s2[CMP_LUV] |=> !charge_en_o && sda_oe_n_o && (s_reg.st == ST_IDLE))
		else $error("activity during logic undervoltage");

	a_slave_drive_only: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		!sda_oe_n_o |-> (s_reg.st == ST_ACK) || (s_reg.st == ST_TX))
		else $error("sda driven outside ack or data phase");

	a_address_match: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(s_reg.st == ST_ACK) && (s_reg.idx == IDX_ADDR) && !sda_oe_n_o |->
		s_reg.shift[7:1] == DEV_ADDR_8[7:1])
		else $error("acknowledged a foreign address");

	a_volt_clamp: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		s_reg.cmp_s2[CMP_PRESENT] && !s_reg.cmp_s2[CMP_LUV] &&
		(s_reg.volt_word >= VOLT_MAX_MV) |=> volt_dac_o == VDAC_MAX)
		else $error("voltage code not clamped");

	a_curr_clamp: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		s_reg.cmp_s2[CMP_PRESENT] && !s_reg.cmp_s2[CMP_LUV] && !s_reg.uv_latch &&
		(s_reg.cur_word > CURR_MAX_MA) |=> curr_dac_o == CDAC_MAX)
		else $error("current code not clamped");

	a_alarm_clear_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(s_reg.st == ST_ACK) && !s_reg.rd && (s_reg.idx == IDX_HI) &&
		((s_reg.cmd == CMD_CURRENT) || (s_reg.cmd == CMD_VOLTAGE)) &&
		(!s_reg.scl_s2 && s_reg.scl_d) && !s_reg.cmp_s2[CMP_ALARM] |=> !s_reg.alarm_latch)
		else $error("alarm latch kept after setpoint write");

endmodule
`default_nettype wire

//--- logic/smbus_charger_pkg.sv
`default_nettype none
package smbus_charger_pkg;
	// Slave address in its 8-bit write form; bit 0 carries the direction.
	localparam logic [7:0] DEV_ADDR_8   = 8'h12;
	localparam logic [7:0] CMD_SPEC     = 8'h11;
	localparam logic [7:0] CMD_MODE     = 8'h12;
	localparam logic [7:0] CMD_STATUS   = 8'h13;
	localparam logic [7:0] CMD_CURRENT  = 8'h14;
	localparam logic [7:0] CMD_VOLTAGE  = 8'h15;

	// Field positions of charge_control_word.
	localparam int MODE_INHIBIT_BIT  = 0;
	localparam int MODE_POR_BIT      = 3;
	localparam int MODE_OVERTEMP_HALT_CTL_BIT = 5;

	// Field positions of condition_flags_word.
	localparam int ST_ADAPTER_BIT = 15;
	localparam int ST_PRESENT_BIT = 14;
	localparam int ST_PFAIL_BIT   = 13;
	localparam int ST_ALARM_BIT   = 12;
	localparam int ST_HOT_BIT     = 11;
	localparam int ST_UR_BIT      = 10;
	localparam int ST_HALT_BIT    = 1;
	localparam int ST_INHIBIT_BIT = 0;

	// Setpoint scaling, in millivolts and milliamps.
	localparam logic [15:0] VOLT_MAX_MV  = 16'h4800;
	localparam logic [15:0] VOLT_MIN_MV  = 16'h0400;
	localparam logic [15:0] CURR_MAX_MA  = 16'h0BC0;
	localparam logic [15:0] CURR_MIN_MA  = 16'h0080;
	localparam logic [15:0] VOLT_RESET   = 16'h0000;
	localparam logic [15:0] CURR_RESET   = 16'h0000;
	localparam int          VDAC_LSB_POS = 4;
	localparam int          CDAC_LSB_POS = 6;
	localparam logic [10:0] VDAC_MAX     = 11'h480;
	localparam logic [5:0]  CDAC_MAX     = 6'h2F;
	localparam logic [5:0]  CDAC_MIN     = 6'h02;

	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [1:0] IDX_ADDR      = 2'h0;
	localparam logic [1:0] IDX_CMD       = 2'h1;
	localparam logic [1:0] IDX_LO        = 2'h2;
	localparam logic [1:0] IDX_HI        = 2'h3;

	// Positions of the comparator inputs in the synchroniser vector.
	localparam int CMP_ADAPTER = 0;
	localparam int CMP_PFAIL   = 1;
	localparam int CMP_PRESENT = 2;
	localparam int CMP_UV_LOW  = 3;
	localparam int CMP_UV_HIGH = 4;
	localparam int CMP_HOT     = 5;
	localparam int CMP_UR      = 6;
	localparam int CMP_ALARM   = 7;
	localparam int CMP_LUV     = 8;
	localparam int CMP_COUNT   = 9;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RX,
		ST_ACK,
		ST_TX,
		ST_RACK,
		ST_IGNORE
	} smb_state_t;
endpackage
`default_nettype wire

//--- tb/smbus_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module smbus_host_model (
	// Clock
	input  wire logic clk_sys_i,
	// Bus
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_o
);
	// Both lines rest released, so the pull-up holds them high between frames.
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end

	task automatic hc(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask

	// Data changes only in mid-low so it never looks like a start or stop.
	task automatic bit_io(input logic b, output logic r);
		hc(2);
		sda_o = b;
		hc(2);
		scl_o = 1'b1;
		hc(2);
		r = sda_i;
		hc(2);
		scl_o = 1'b0;
	endtask

	task automatic start_c();
		if (!scl_o) begin
			hc(2);
			sda_o = 1'b1;
			hc(2);
			scl_o = 1'b1;
		end
		hc(4);
		sda_o = 1'b0;
		hc(4);
		scl_o = 1'b0;
	endtask

	task automatic stop_c();
		hc(2);
		sda_o = 1'b0;
		hc(2);
		scl_o = 1'b1;
		hc(4);
		sda_o = 1'b1;
		hc(4);
	endtask

	// Sending 0xFF leaves the line free for the device to drive read data.
	task automatic xfer(input logic [7:0] b, input logic last, output logic [7:0] r,
		output logic ack);
		logic x;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], x);
			r[i] = x;
		end
		bit_io(last, ack);
	endtask

	task automatic write_word(input logic [7:0] a, input logic [7:0] c,
		input logic [15:0] d, output logic ok);
		logic [7:0] r;
		logic k0, k1, k2, k3;
		start_c();
		xfer(a, 1'b1, r, k0);
		xfer(c, 1'b1, r, k1);
		xfer(d[7:0], 1'b1, r, k2);
		xfer(d[15:8], 1'b1, r, k3);
		stop_c();
		ok = !(k0 | k1 | k2 | k3);
	endtask

	task automatic read_word(input logic [7:0] a, input logic [7:0] c,
		output logic [15:0] d, output logic ok);
		logic [7:0] r;
		logic k0, k1, k2, k3;
		start_c();
		xfer(a, 1'b1, r, k0);
		xfer(c, 1'b1, r, k1);
		start_c();
		xfer(a | 8'h01, 1'b1, r, k2);
		xfer(8'hFF, 1'b0, d[7:0], k3);
		xfer(8'hFF, 1'b1, d[15:8], k3);
		stop_c();
		ok = !(k0 | k1 | k2);
	endtask
endmodule
`default_nettype wire

//--- tb/smart_charger_smbus_control_bench.sv
`timescale 1ns/100ps
`default_nettype none
module smart_charger_smbus_control_bench;
	import smbus_charger_pkg::*;
	logic        clk_sys_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        scl, host_sda, sda_o, sda_oe_n_o;
	logic        adapter_ok_flag_i = 1'b1, power_fail_i = 1'b0, pack_present_i = 1'b0;
	logic        pack_uv_low_i = 1'b0, pack_uv_high_i = 1'b1, pack_overtemp_i = 1'b0;
	logic        pack_sense_underrange_i = 1'b0, alarm_event_i = 1'b0, logic_uv_i = 1'b0;
	logic        charge_en_o, source_switch_drive_o;
	logic [10:0] volt_dac_o;
	logic [5:0]  curr_dac_o;
	int          err_count = 0;
	int          cmp_count = 0;
	wire logic   sda_w = host_sda & (sda_oe_n_o | sda_o);

	always #20 clk_sys_i = ~clk_sys_i;

	smart_charger_smbus_control smart_charger_smbus_control_inst (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_w),
		.sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .adapter_ok_flag_i(adapter_ok_flag_i),
		.power_fail_i(power_fail_i), .pack_present_i(pack_present_i),
		.pack_uv_low_i(pack_uv_low_i), .pack_uv_high_i(pack_uv_high_i),
		.pack_overtemp_i(pack_overtemp_i), .pack_sense_underrange_i(pack_sense_underrange_i),
		.alarm_event_i(alarm_event_i), .logic_uv_i(logic_uv_i), .charge_en_o(charge_en_o),
		.source_switch_drive_o(source_switch_drive_o), .volt_dac_o(volt_dac_o),
		.curr_dac_o(curr_dac_o)
	);

	smbus_host_model smbus_host_model_inst (
		.clk_sys_i(clk_sys_i), .sda_i(sda_w), .scl_o(scl), .sda_o(host_sda)
	);

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic check(input string n, input logic [23:0] seen, input logic [23:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, exp, seen);
		end
	endtask

	task automatic st();
		repeat (8) @(negedge clk_sys_i);
	endtask

	// Source switch is expected on here; the power-fail case checks it alone.
	task automatic co(input logic e, input logic [10:0] v, input logic [5:0] c);
		check("controls", {5'h00, charge_en_o, source_switch_drive_o, volt_dac_o, curr_dac_o},
			{5'h00, e, 1'b1, v, c});
	endtask

	task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic ack);
		logic ok;
		smbus_host_model_inst.write_word(DEV_ADDR_8, c, d, ok);
		check("write ack", {23'h000000, ok}, {23'h000000, ack});
		st();
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] c, input logic [15:0] exp);
		logic [15:0] d;
		logic ok;
		smbus_host_model_inst.read_word(a, c, d, ok);
		check("read ack", {23'h000000, ok}, {23'h000000, a == DEV_ADDR_8});
		check("read data", {8'h00, d}, {8'h00, exp});
	endtask

	task automatic t_reset();
		repeat (2) @(negedge clk_sys_i);
		check("reset pins", {sda_oe_n_o, charge_en_o, source_switch_drive_o, 21'h0},
			{3'h4, 21'h000000});
		check("reset dacs", {7'h00, volt_dac_o, curr_dac_o}, {7'h00, 11'h480, 6'h02});
		rst_i = 1'b0;
		st();
		co(1'b1, 11'h480, 6'h02);
		$display("t_reset done");
	endtask

	task automatic t_status();
		pack_present_i = 1'b1;
		st();
		rd(DEV_ADDR_8, CMD_STATUS, 16'hC002);
		rd(DEV_ADDR_8, CMD_SPEC, 16'h00A5);
		rd(8'h14, CMD_SPEC, 16'hFFFF);
		power_fail_i = 1'b1;
		pack_sense_underrange_i = 1'b1;
		st();
		check("source switch", {23'h000000, source_switch_drive_o}, 24'h000000);
		rd(DEV_ADDR_8, CMD_STATUS, 16'hE402);
		power_fail_i = 1'b0;
		pack_sense_underrange_i = 1'b0;
		st();
		$display("t_status done");
	endtask

	task automatic t_setpoints();
		logic [7:0]  sc [9] = '{CMD_CURRENT, CMD_VOLTAGE, CMD_VOLTAGE, CMD_VOLTAGE,
			CMD_VOLTAGE, CMD_CURRENT, CMD_CURRENT, CMD_CURRENT, CMD_CURRENT};
		logic [15:0] sd [9] = '{16'h0400, 16'h3000, 16'h5000, 16'h03F0, 16'h0400,
			16'h1000, 16'h0020, 16'h0080, 16'h0400};
		logic [17:0] sx [9] = '{{1'b0, 11'h000, 6'h10}, {1'b1, 11'h300, 6'h10},
			{1'b1, 11'h480, 6'h10}, {1'b0, 11'h03F, 6'h10}, {1'b1, 11'h040, 6'h10},
			{1'b1, 11'h040, 6'h2F}, {1'b0, 11'h040, 6'h00}, {1'b1, 11'h040, 6'h02},
			{1'b1, 11'h040, 6'h10}};
		for (int i = 0; i < 9; i++) begin
			wr(sc[i], sd[i], 1'b1);
			co(sx[i][17], sx[i][16:6], sx[i][5:0]);
		end
		$display("t_setpoints done");
	endtask

	task automatic t_undervolt();
		pack_uv_high_i = 1'b0;
		pack_uv_low_i = 1'b1;
		st();
		co(1'b1, 11'h040, 6'h02);
		pack_uv_low_i = 1'b0;
		st();
		co(1'b1, 11'h040, 6'h02);
		pack_uv_high_i = 1'b1;
		st();
		co(1'b1, 11'h040, 6'h10);
		$display("t_undervolt done");
	endtask

	task automatic t_latches();
		alarm_event_i = 1'b1;
		st();
		alarm_event_i = 1'b0;
		st();
		rd(DEV_ADDR_8, CMD_STATUS, 16'hD002);
		wr(CMD_CURRENT, 16'h0400, 1'b1);
		rd(DEV_ADDR_8, CMD_STATUS, 16'hC002);
		pack_overtemp_i = 1'b1;
		st();
		pack_overtemp_i = 1'b0;
		st();
		rd(DEV_ADDR_8, CMD_STATUS, 16'hC802);
		co(1'b0, 11'h040, 6'h10);
		wr(CMD_MODE, 16'h0000, 1'b1);
		co(1'b1, 11'h040, 6'h10);
		wr(8'h20, 16'hFFFF, 1'b0);
		rd(DEV_ADDR_8, CMD_STATUS, 16'hC800);
		co(1'b1, 11'h040, 6'h10);
		wr(CMD_MODE, 16'h0008, 1'b1);
		rd(DEV_ADDR_8, CMD_STATUS, 16'hC002);
		co(1'b0, 11'h000, 6'h00);
		$display("t_latches done");
	endtask

	task automatic t_removal();
		wr(CMD_CURRENT, 16'h0400, 1'b1);
		wr(CMD_VOLTAGE, 16'h3000, 1'b1);
		wr(CMD_MODE, 16'h0000, 1'b1);
		co(1'b1, 11'h300, 6'h10);
		adapter_ok_flag_i = 1'b0;
		st();
		co(1'b0, 11'h300, 6'h10);
		rd(DEV_ADDR_8, CMD_STATUS, 16'h4000);
		adapter_ok_flag_i = 1'b1;
		wr(CMD_MODE, 16'h0021, 1'b1);
		co(1'b0, 11'h300, 6'h10);
		pack_overtemp_i = 1'b1;
		st();
		pack_overtemp_i = 1'b0;
		rd(DEV_ADDR_8, CMD_STATUS, 16'hC803);
		pack_present_i = 1'b0;
		st();
		co(1'b1, 11'h480, 6'h02);
		pack_present_i = 1'b1;
		st();
		co(1'b0, 11'h000, 6'h00);
		rd(DEV_ADDR_8, CMD_STATUS, 16'hC002);
		$display("t_removal done");
	endtask

	task automatic t_logic_uv();
		wr(CMD_CURRENT, 16'h0400, 1'b1);
		wr(CMD_VOLTAGE, 16'h3000, 1'b1);
		logic_uv_i = 1'b1;
		st();
		co(1'b0, 11'h480, 6'h02);
		wr(CMD_CURRENT, 16'h1000, 1'b0);
		logic_uv_i = 1'b0;
		st();
		co(1'b0, 11'h000, 6'h00);
		rd(DEV_ADDR_8, CMD_STATUS, 16'hC002);
		$display("t_logic_uv done");
	endtask

	initial begin
		t_reset();
		t_status();
		t_setpoints();
		t_undervolt();
		t_latches();
		t_removal();
		t_logic_uv();
		print_verdict();
	end

	// About 35 word transfers of some 350 cycles each, with ample margin.
	initial begin
		repeat (60000) @(posedge clk_sys_i);
		err_count++;
		print_verdict();
	end
endmodule
`default_nettype wire
